// ---- hdl/crm_pkg.sv ----
// Constants, register map and carrier types of the receive mask and buffer flag block.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
package crm_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned CRM_NUM_FILT = 8;
   localparam int unsigned CRM_FIRST_FILT = 8;
   localparam int unsigned CRM_NUM_MASK = 3;
   localparam int unsigned CRM_NUM_BUF = 32;
   localparam int unsigned CRM_ADDR_W = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CRM_OFS_MASK_SEL = 8'h00;
   localparam logic [7:0] CRM_OFS_M0_SID = 8'h04;
   localparam logic [7:0] CRM_OFS_M0_EID = 8'h08;
   localparam logic [7:0] CRM_OFS_M1_SID = 8'h0c;
   localparam logic [7:0] CRM_OFS_M1_EID = 8'h10;
   localparam logic [7:0] CRM_OFS_M2_SID = 8'h14;
   localparam logic [7:0] CRM_OFS_M2_EID = 8'h18;
   localparam logic [7:0] CRM_OFS_FULL_LO = 8'h1c;
   localparam logic [7:0] CRM_OFS_FULL_HI = 8'h20;
   localparam logic [7:0] CRM_OFS_OVF_LO = 8'h24;
   localparam logic [7:0] CRM_OFS_OVF_HI = 8'h28;
   localparam logic [7:0] CRM_OFS_IRQ_STAT = 8'h2c;
   localparam logic [7:0] CRM_OFS_IRQ_MASK = 8'h30;

   // ==========================================================
   // Field positions and codes
   localparam int unsigned CRM_SID_LSB = 5;
   localparam int unsigned CRM_MODE_BIT = 3;
   localparam logic [1:0] CRM_MSEL_RSVD = 2'h3;
   localparam logic [3:0] CRM_PTR_FIFO = 4'hf;
   localparam int unsigned CRM_EV_STORE = 0;
   localparam int unsigned CRM_EV_OVF = 1;

   // ==========================================================
   // Reset values
   localparam logic [15:0] CRM_RST_MASK_SEL = 16'h0000;
   localparam logic [31:0] CRM_RST_FLAGS = 32'h0000_0000;
   localparam logic [1:0] CRM_RST_IRQ = 2'h0;

   localparam logic [1:0] CRM_RESP_OKAY = 2'h0;
   localparam logic [1:0] CRM_RESP_SLVERR = 2'h2;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic ext;
      logic [10:0] sid;
      logic [17:0] eid;
   } crm_frame_s;

   typedef struct packed {
      logic ext_enable;
      logic [10:0] sid;
      logic [17:0] eid;
   } crm_filter_s;

   typedef struct packed {
      logic mode;
      logic [10:0] sid;
      logic [17:0] eid;
   } crm_mask_s;

endpackage : crm_pkg

// ---- hdl/crm_rx_mask.sv ----
// Acceptance mask selection for filters 8 to 15, mask registers and receive buffer flags.
// Assumes filter identifiers and buffer pointers come from registers outside this block.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns

// Operation
// - Two-bit source code picks mask 0, 1, 2.
// - Filter 15 at bits 15-14 down to 8.
// - Standard mask bit one includes, zero ignores.
// - Extended mask bits include when one, ignore zero.
// - Mode one: frame type must match filter enable.
// - Mode zero: standard or combined identifier match passes.
// - Mask bits 4 and 2 read zero.
// - Storing a message sets that buffer's full flag.
// - Storing into full buffer sets its overflow flag.
// - Flags and sources reset zero; masks undefined.
// - Filter type enable: one extended, zero standard.
// - Included bits must equal filter's stored bits.
module crm_rx_mask #(
   parameter int unsigned NUM_FILT = crm_pkg::CRM_NUM_FILT
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // AXI4-Lite write channels
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [crm_pkg::CRM_ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   // AXI4-Lite read channels
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [crm_pkg::CRM_ADDR_W-1:0] i_s_axi_araddr,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   // Received frame and filter settings
   input wire logic i_rx_valid,
   input wire crm_pkg::crm_frame_s i_rx_frame,
   input wire crm_pkg::crm_filter_s [NUM_FILT-1:0] i_filters,
   input wire logic [NUM_FILT-1:0][3:0] i_filter_buf_ptr,
   // Stores into FIFO buffers made elsewhere
   input wire logic i_fifo_store_valid,
   input wire logic [4:0] i_fifo_store_buf,
   // Hit report and interrupt
   output logic o_hit_valid,
   output logic [3:0] o_hit_filter,
   output logic [3:0] o_hit_buf_ptr,
   output logic o_irq
);

   // ==========================================================
   // Elaboration check
   if (NUM_FILT < 1 || NUM_FILT > crm_pkg::CRM_NUM_FILT) begin : g_bad_num_filt
      $error("NUM_FILT must lie between 1 and 8.");
   end

   // ==========================================================
   // State
   logic [15:0] mask_sel_q;
   crm_pkg::crm_mask_s masks_q [crm_pkg::CRM_NUM_MASK];
   logic [31:0] full_q;
   logic [31:0] ovf_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [crm_pkg::CRM_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [15:0] lane_mask;
   logic [15:0] wr16;
   logic wr_map_ok;

   // ==========================================================
   // Write path: address and data taken in either order.
   assign do_write = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
   assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr16 = wdata_q[15:0];

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready <= 1'b1;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            o_s_axi_awready <= 1'b0;
            awaddr_q <= i_s_axi_awaddr;
         end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_awready <= 1'b1;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            o_s_axi_wready <= 1'b0;
            wdata_q <= i_s_axi_wdata;
            wstrb_q <= i_s_axi_wstrb;
         end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      unique case (awaddr_q)
         crm_pkg::CRM_OFS_MASK_SEL, crm_pkg::CRM_OFS_M0_SID, crm_pkg::CRM_OFS_M0_EID,
         crm_pkg::CRM_OFS_M1_SID, crm_pkg::CRM_OFS_M1_EID, crm_pkg::CRM_OFS_M2_SID,
         crm_pkg::CRM_OFS_M2_EID, crm_pkg::CRM_OFS_FULL_LO, crm_pkg::CRM_OFS_FULL_HI,
         crm_pkg::CRM_OFS_OVF_LO, crm_pkg::CRM_OFS_OVF_HI, crm_pkg::CRM_OFS_IRQ_STAT,
         crm_pkg::CRM_OFS_IRQ_MASK: wr_map_ok = 1'b1;
         default: wr_map_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= crm_pkg::CRM_RESP_OKAY;
      end else if (do_write) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp <= wr_map_ok ? crm_pkg::CRM_RESP_OKAY : crm_pkg::CRM_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mask_sel_q <= crm_pkg::CRM_RST_MASK_SEL;
         irq_mask_q <= crm_pkg::CRM_RST_IRQ;
      end else if (do_write) begin
         if (awaddr_q == crm_pkg::CRM_OFS_MASK_SEL) begin
            mask_sel_q <= (mask_sel_q & ~lane_mask) | (wr16 & lane_mask);
         end
         if (awaddr_q == crm_pkg::CRM_OFS_IRQ_MASK && wstrb_q[0]) begin
            irq_mask_q <= wdata_q[1:0];
         end
      end
   end

   // Masks carry no reset, so software must load them before enabling reception.
   for (genvar m = 0; m < crm_pkg::CRM_NUM_MASK; m++) begin : g_mask
      localparam logic [7:0] SID_OFS = crm_pkg::CRM_OFS_M0_SID + 8'(8 * m);
      localparam logic [7:0] EID_OFS = crm_pkg::CRM_OFS_M0_EID + 8'(8 * m);
      always_ff @(posedge i_sys_clk) begin
         if (do_write && awaddr_q == SID_OFS) begin
            if (wstrb_q[1]) begin
               masks_q[m].sid[10:3] <= wr16[15:8];
            end
            if (wstrb_q[0]) begin
               masks_q[m].sid[2:0] <= wr16[7:crm_pkg::CRM_SID_LSB];
               masks_q[m].mode <= wr16[crm_pkg::CRM_MODE_BIT];
               masks_q[m].eid[17:16] <= wr16[1:0];
            end
         end
         if (do_write && awaddr_q == EID_OFS) begin
            if (wstrb_q[1]) begin
               masks_q[m].eid[15:8] <= wr16[15:8];
            end
            if (wstrb_q[0]) begin
               masks_q[m].eid[7:0] <= wr16[7:0];
            end
         end
      end
   end

   // ==========================================================
   // Filter comparison, one per filter
   logic [NUM_FILT-1:0] hit;

   for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
      logic [1:0] src;
      crm_pkg::crm_mask_s msk;
      logic sid_ok;
      logic full_ok;
      logic type_ok;
      assign src = mask_sel_q[2*f+1 -: 2];
      always_comb begin
         unique case (src)
            2'h0: msk = masks_q[0];
            2'h1: msk = masks_q[1];
            2'h2: msk = masks_q[2];
            default: msk = '0;
         endcase
      end
      // Included bits must equal the stored bits; excluded bits never matter.
      assign sid_ok = ((i_rx_frame.sid ^ i_filters[f].sid) & msk.sid) == '0;
      assign full_ok = sid_ok && (((i_rx_frame.eid ^ i_filters[f].eid) & msk.eid) == '0);
      assign type_ok = i_rx_frame.ext == i_filters[f].ext_enable;
      always_comb begin
         // The reserved source code is refused here so a bad setting cannot accept frames.
         if (src == crm_pkg::CRM_MSEL_RSVD) begin
            hit[f] = 1'b0;
         end else if (msk.mode) begin
            hit[f] = type_ok && (i_rx_frame.ext ? full_ok : sid_ok);
         end else begin
            hit[f] = sid_ok || full_ok;
         end
      end
   end

   // Lowest numbered filter that hits wins.
   logic any_hit;
   logic [3:0] win_idx;
   logic [3:0] win_ptr;

   always_comb begin
      any_hit = 1'b0;
      win_idx = '0;
      win_ptr = '0;
      for (int k = NUM_FILT - 1; k >= 0; k--) begin
         if (hit[k]) begin
            any_hit = 1'b1;
            win_idx = 4'(k);
            win_ptr = i_filter_buf_ptr[k];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hit_valid <= 1'b0;
         o_hit_filter <= '0;
         o_hit_buf_ptr <= '0;
      end else begin
         o_hit_valid <= i_rx_valid && any_hit;
         if (i_rx_valid && any_hit) begin
            o_hit_filter <= 4'(crm_pkg::CRM_FIRST_FILT) + win_idx;
            o_hit_buf_ptr <= win_ptr;
         end
      end
   end

   // ==========================================================
   // Buffer flags
   logic [31:0] set_vec;
   logic [31:0] full_clr;
   logic [31:0] ovf_clr;

   always_comb begin
      set_vec = '0;
      if (i_rx_valid && any_hit && win_ptr != crm_pkg::CRM_PTR_FIFO) begin
         set_vec[win_ptr] = 1'b1;
      end
      if (i_fifo_store_valid) begin
         set_vec[i_fifo_store_buf] = 1'b1;
      end
      full_clr = '0;
      ovf_clr = '0;
      if (do_write) begin
         unique case (awaddr_q)
            crm_pkg::CRM_OFS_FULL_LO: full_clr[15:0] = ~wr16 & lane_mask;
            crm_pkg::CRM_OFS_FULL_HI: full_clr[31:16] = ~wr16 & lane_mask;
            crm_pkg::CRM_OFS_OVF_LO: ovf_clr[15:0] = ~wr16 & lane_mask;
            crm_pkg::CRM_OFS_OVF_HI: ovf_clr[31:16] = ~wr16 & lane_mask;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         full_q <= crm_pkg::CRM_RST_FLAGS;
         ovf_q <= crm_pkg::CRM_RST_FLAGS;
      end else begin
         full_q <= (full_q & ~full_clr) | set_vec;
         ovf_q <= (ovf_q & ~ovf_clr) | (set_vec & full_q);
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear, set wins
   logic [1:0] ev;
   logic [1:0] irq_clr;

   assign ev = {|(set_vec & full_q), |set_vec};
   assign irq_clr = (do_write && awaddr_q == crm_pkg::CRM_OFS_IRQ_STAT && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_stat_q <= crm_pkg::CRM_RST_IRQ;
         o_irq <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
         o_irq <= |(((irq_stat_q & ~irq_clr) | ev) & irq_mask_q);
      end
   end

   // ==========================================================
   // Read path
   logic [31:0] rd_data;
   logic rd_ok;

   always_comb begin
      rd_data = '0;
      rd_ok = 1'b1;
      unique case (i_s_axi_araddr)
         crm_pkg::CRM_OFS_MASK_SEL: rd_data[15:0] = mask_sel_q;
         crm_pkg::CRM_OFS_M0_SID: rd_data[15:0] = {masks_q[0].sid, 1'b0, masks_q[0].mode, 1'b0,
                                                  masks_q[0].eid[17:16]};
         crm_pkg::CRM_OFS_M0_EID: rd_data[15:0] = masks_q[0].eid[15:0];
         crm_pkg::CRM_OFS_M1_SID: rd_data[15:0] = {masks_q[1].sid, 1'b0, masks_q[1].mode, 1'b0,
                                                  masks_q[1].eid[17:16]};
         crm_pkg::CRM_OFS_M1_EID: rd_data[15:0] = masks_q[1].eid[15:0];
         crm_pkg::CRM_OFS_M2_SID: rd_data[15:0] = {masks_q[2].sid, 1'b0, masks_q[2].mode, 1'b0,
                                                  masks_q[2].eid[17:16]};
         crm_pkg::CRM_OFS_M2_EID: rd_data[15:0] = masks_q[2].eid[15:0];
         crm_pkg::CRM_OFS_FULL_LO: rd_data[15:0] = full_q[15:0];
         crm_pkg::CRM_OFS_FULL_HI: rd_data[15:0] = full_q[31:16];
         crm_pkg::CRM_OFS_OVF_LO: rd_data[15:0] = ovf_q[15:0];
         crm_pkg::CRM_OFS_OVF_HI: rd_data[15:0] = ovf_q[31:16];
         crm_pkg::CRM_OFS_IRQ_STAT: rd_data[1:0] = irq_stat_q;
         crm_pkg::CRM_OFS_IRQ_MASK: rd_data[1:0] = irq_mask_q;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= '0;
         o_s_axi_rresp <= crm_pkg::CRM_RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_data;
         o_s_axi_rresp <= rd_ok ? crm_pkg::CRM_RESP_OKAY : crm_pkg::CRM_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
      end
   end

endmodule : crm_rx_mask

// ---- testbench/crm_rx_mask_monitor.sv ----
// Concurrent checks on the register bus and hit report of the receive mask block.
// Assumes it is bound to crm_rx_mask and sees only that module's ports.
`timescale 1ns/1ns

// ==========================================================
// Checker
module crm_rx_mask_monitor (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // Register bus
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [crm_pkg::CRM_ADDR_W-1:0] i_s_axi_araddr,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic [1:0] o_s_axi_rresp,
   // Frame path
   input wire logic i_rx_valid,
   input wire logic o_hit_valid,
   input wire logic [3:0] o_hit_filter
);
   logic [7:0] rd_addr_q;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   // The read address is kept so that the returned word can be judged against its register.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_addr_q <= 8'h00;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         rd_addr_q <= i_s_axi_araddr;
      end
   end

   a_hit_needs_frame: assert property (o_hit_valid |-> $past(i_rx_valid))
      else $error("hit reported without a frame");
   a_hit_filter_range: assert property (o_hit_valid |-> o_hit_filter[3] == 1'b1)
      else $error("hit filter outside 8 to 15");
   a_hit_filter_hold: assert property (!o_hit_valid |-> $stable(o_hit_filter))
      else $error("hit filter moved without a hit");
   a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      |-> ##2 o_s_axi_bvalid) else $error("write answer late");
   a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write answer dropped early");
   a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read answer dropped early");
   a_read_unmapped: assert property (o_s_axi_rvalid && rd_addr_q >= 8'h34
      |-> o_s_axi_rresp == crm_pkg::CRM_RESP_SLVERR && o_s_axi_rdata == 32'h0) else $error("unmapped read");
   a_sid_gaps_zero: assert property (o_s_axi_rvalid && rd_addr_q inside {8'h04, 8'h0c, 8'h14}
      |-> o_s_axi_rdata[4] == 1'b0 && o_s_axi_rdata[2] == 1'b0) else $error("mask gap bits not zero");
endmodule : crm_rx_mask_monitor

bind crm_rx_mask crm_rx_mask_monitor crm_rx_mask_monitor_inst (.i_sys_clk, .i_nrst, .i_s_axi_awvalid,
   .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp,
   .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
   .o_s_axi_rresp, .i_rx_valid, .o_hit_valid, .o_hit_filter);

// ---- testbench/crm_can_node.sv ----
// Model of a remote bus node that hands received frames to the block.
// Assumes send is called from a process that runs on the rising clock edge.
`timescale 1ns/1ns

// ==========================================================
// Frame source
module crm_can_node (
   // Clock
   input wire logic i_clk,
   // Frame out
   output logic o_valid,
   output crm_pkg::crm_frame_s o_frame
);
   initial begin
      o_valid = 1'b0;
      o_frame = '0;
   end

   // Between frames the identifier lines carry the inverse, so stale data never looks valid.
   task automatic send(input crm_pkg::crm_frame_s f);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_frame <= f;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_frame <= ~f;
   endtask : send
endmodule : crm_can_node

// ---- testbench/crm_rx_mask_tb_top.sv ----
// Self-checking bench of the receive mask and buffer flag block.
// Assumes the package, the design, the frame source model and the checker are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end

module crm_rx_mask_tb_top;
   logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_rx_valid, o_irq, o_hit_valid;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
   logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, i_fifo_store_valid = 1'b0;
   logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
   logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rdat;
   logic [3:0] i_s_axi_wstrb = 4'h3, o_hit_filter, o_hit_buf_ptr;
   logic [4:0] i_fifo_store_buf = 5'h00;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
   crm_pkg::crm_filter_s [7:0] i_filters;
   logic [7:0][3:0] i_filter_buf_ptr;
   crm_pkg::crm_frame_s i_rx_frame;
   crm_pkg::crm_mask_s masks [3];
   crm_pkg::crm_frame_s frames [4] = '{{1'b0, 11'h2a5, 18'h00000}, {1'b1, 11'h2a5, 18'h15a5a},
      {1'b1, 11'h2a3, 18'h15a5b}, {1'b0, 11'h3a5, 18'h15a5a}};
   int n_errors = 0, cmp_count = 0, cycles = 0;

   always #2 i_sys_clk = ~i_sys_clk;

   crm_rx_mask crm_rx_mask_inst (.i_sys_clk, .i_nrst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_awaddr,
      .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata, .i_s_axi_wstrb, .o_s_axi_bvalid, .i_s_axi_bready,
      .o_s_axi_bresp, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready,
      .o_s_axi_rdata, .o_s_axi_rresp, .i_rx_valid, .i_rx_frame, .i_filters, .i_filter_buf_ptr,
      .i_fifo_store_valid, .i_fifo_store_buf, .o_hit_valid, .o_hit_filter, .o_hit_buf_ptr, .o_irq);
   crm_can_node crm_can_node_inst (.i_clk(i_sys_clk), .o_valid(i_rx_valid), .o_frame(i_rx_frame));

   // ==========================================================
   // Bus cycles
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic aw_done;
      logic w_done;
      @(posedge i_sys_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= {16'h0000, d};
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge i_sys_clk);
         if (!aw_done && o_s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            i_s_axi_awvalid <= 1'b0;
         end
         if (!w_done && o_s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            i_s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge i_sys_clk); while (o_s_axi_bvalid !== 1'b1);
      i_s_axi_bready <= 1'b0;
      resp = o_s_axi_bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      do @(posedge i_sys_clk); while (o_s_axi_arready !== 1'b1);
      i_s_axi_arvalid <= 1'b0;
      do @(posedge i_sys_clk); while (o_s_axi_rvalid !== 1'b1);
      i_s_axi_rready <= 1'b0;
      rdat = o_s_axi_rdata;
      resp = o_s_axi_rresp;
   endtask : rd

   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      rd(a);
      `CHK(rdat, {16'h0000, e})
      `CHK(resp, crm_pkg::CRM_RESP_OKAY)
   endtask : chk_rd

   task automatic set_mask(input int i, input crm_pkg::crm_mask_s m);
      masks[i] = m;
      wr(crm_pkg::CRM_OFS_M0_SID + 8'(8 * i), {m.sid, 1'b0, m.mode, 1'b0, m.eid[17:16]});
      wr(crm_pkg::CRM_OFS_M0_EID + 8'(8 * i), m.eid[15:0]);
   endtask : set_mask

   task automatic store(input logic [4:0] b);
      @(posedge i_sys_clk);
      i_fifo_store_valid <= 1'b1;
      i_fifo_store_buf <= b;
      @(posedge i_sys_clk);
      i_fifo_store_valid <= 1'b0;
   endtask : store

   // Mode zero passes on the standard identifier alone, whatever the frame type.
   function automatic logic exp_hit(crm_pkg::crm_mask_s m, crm_pkg::crm_filter_s f, crm_pkg::crm_frame_s x);
      logic s;
      logic e;
      s = ((f.sid ^ x.sid) & m.sid) == 11'h000;
      e = ((f.eid ^ x.eid) & m.eid) == 18'h00000;
      return m.mode ? (x.ext == f.ext_enable) && s && (!x.ext || e) : s;
   endfunction : exp_hit

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      foreach (masks[i]) chk_rd(crm_pkg::CRM_OFS_FULL_LO + 8'(4 * i), 16'h0000);
      chk_rd(crm_pkg::CRM_OFS_OVF_HI, 16'h0000);
      chk_rd(crm_pkg::CRM_OFS_MASK_SEL, 16'h0000);
   endtask : t_reset

   task automatic t_regs;
      wr(crm_pkg::CRM_OFS_M0_SID, 16'hffff);
      chk_rd(crm_pkg::CRM_OFS_M0_SID, 16'hffeb);
      wr(crm_pkg::CRM_OFS_MASK_SEL, 16'h9461);
      chk_rd(crm_pkg::CRM_OFS_MASK_SEL, 16'h9461);
      wr(8'h40, 16'h1234);
      `CHK(resp, crm_pkg::CRM_RESP_SLVERR)
      rd(8'h40);
      `CHK(rdat, 32'h0)
   endtask : t_regs

   // Only legal source codes are used, so every filter may hit and the lowest hitting one must win.
   task automatic t_select;
      logic [15:0] sel;
      logic [1:0] code [8];
      logic exp;
      int win;
      set_mask(0, {1'b0, 11'h7ff, 18'h00000});
      set_mask(1, {1'b1, 11'h7f0, 18'h3ffff});
      set_mask(2, {1'b1, 11'h000, 18'h00000});
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 8; k++) begin
            code[k] = 2'((k + p) % 3);
            sel[2 * k +: 2] = code[k];
         end
         wr(crm_pkg::CRM_OFS_MASK_SEL, sel);
         for (int f = 0; f < 4; f++) begin
            crm_can_node_inst.send(frames[f]);
            win = -1;
            for (int k = 7; k >= 0; k--) begin
               if (exp_hit(masks[code[k]], i_filters[k], frames[f])) win = k;
            end
            exp = (win >= 0);
            #1;
            `CHK(o_hit_valid, exp)
            if (exp) `CHK(o_hit_filter, 4'(8 + win))
            if (exp) `CHK(o_hit_buf_ptr, i_filter_buf_ptr[win])
         end
      end
   endtask : t_select

   task automatic t_flags;
      wr(crm_pkg::CRM_OFS_FULL_LO, 16'h0000);
      wr(crm_pkg::CRM_OFS_OVF_LO, 16'h0000);
      wr(crm_pkg::CRM_OFS_IRQ_STAT, 16'h0003);
      wr(crm_pkg::CRM_OFS_IRQ_MASK, 16'h0002);
      chk_rd(crm_pkg::CRM_OFS_FULL_LO, 16'h0000);
      store(5'd20);
      chk_rd(crm_pkg::CRM_OFS_FULL_HI, 16'h0010);
      `CHK(o_irq, 1'b0)
      store(5'd20);
      chk_rd(crm_pkg::CRM_OFS_OVF_HI, 16'h0010);
      `CHK(o_irq, 1'b1)
      wr(crm_pkg::CRM_OFS_FULL_HI, 16'hffff);
      chk_rd(crm_pkg::CRM_OFS_FULL_HI, 16'h0010);
      wr(crm_pkg::CRM_OFS_FULL_HI, 16'hffef);
      chk_rd(crm_pkg::CRM_OFS_FULL_HI, 16'h0000);
      chk_rd(crm_pkg::CRM_OFS_OVF_HI, 16'h0010);
      wr(crm_pkg::CRM_OFS_IRQ_STAT, 16'h0002);
      chk_rd(crm_pkg::CRM_OFS_IRQ_STAT, 16'h0001);
      `CHK(o_irq, 1'b0)
      wr(crm_pkg::CRM_OFS_MASK_SEL, 16'haaaa);
      repeat (2) crm_can_node_inst.send(frames[0]);
      chk_rd(crm_pkg::CRM_OFS_FULL_LO, 16'h0001);
      chk_rd(crm_pkg::CRM_OFS_OVF_LO, 16'h0001);
   endtask : t_flags

   task automatic finish_test;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      for (int k = 0; k < 8; k++) begin
         i_filters[k] = {k[0], 11'h2a5, 18'h15a5a};
         i_filter_buf_ptr[k] = 4'(k);
      end
      repeat (5) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      t_reset();
      t_regs();
      t_select();
      t_flags();
      finish_test();
   end
endmodule : crm_rx_mask_tb_top
